// *** design/bmx_bus_switch_fabric.sv ***
// Multi-layer bus switch fabric: per-master decoders, per-slave arbiters
// and the Avalon-MM register file that configures them.
// Assumes masters hold a beat request until granted and slaves pulse
// sReady when the selected beat completes; all on sys_clk.
//
// What this block does
// RULE1: Split 000: open bursts broken only at slot limit
// RULE2: Split 001: rearbitrate after every beat
// RULE3: Split 010: rearbitrate after four beats
// RULE4: Split 011: rearbitrate after eight beats
// RULE5: Split 100: rearbitrate after sixteen beats
// RULE6: Policy bit: 0 round-robin, 1 fixed priority
// RULE7: Parking index used only in fixed parking
// RULE8: Unconnected parking master means no parking
// RULE9: Parking 0: disconnect when idle
// RULE10: Parking 1: stay with last master
// RULE11: Parking 2: connect to parking master
// RULE12: Slot limit reached lets others break burst
// RULE13: Software keeps slot limit reasonable, e.g. 16
// RULE14: Fixed mode: larger priority field wins
// RULE15: Unmapped access answered with error
// RULE16: Each master has own decoder
// RULE17: Each slave has own arbiter
// RULE18: Master fields indexed by master number
// RULE19: Slave registers indexed by slave number
// RULE20: Sixteen uninterpreted read/write side registers
// RULE21: Slot counter restarts on every grant
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module bmx_bus_switch_fabric #(
  parameter int NM = bmx_pkg::NUM_MASTERS,
  parameter int NS = bmx_pkg::NUM_SLAVES,
  // Bit m*NS+s set when master m may reach slave s
  parameter logic [NM*NS-1:0] CONN = '1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  input wire logic [NM-1:0] mReq,
  input wire logic [NM*32-1:0] mAddr,
  input wire logic [NM-1:0] mIncr,
  output logic [NM-1:0] mGnt,
  output logic [NM-1:0] mErr,
  output logic [NS-1:0] sSel,
  output logic [NS*bmx_pkg::MIDX_W-1:0] sMaster,
  input wire logic [NS-1:0] sReady,
  output logic [bmx_pkg::SFR_COUNT*32-1:0] sfrOut
);

  localparam int MW = bmx_pkg::MIDX_W;

  logic [31:0] mcfgReg [NM];
  logic [31:0] scfgReg [NS];
  logic [31:0] priAReg [NS];
  logic [31:0] priBReg [NS];
  logic [31:0] sfrReg [bmx_pkg::SFR_COUNT];
  bmx_pkg::bmx_bus_state_t busStateReg;
  logic [MW-1:0] ownerReg [NS];
  logic [NS-1:0] ownValidReg;
  logic [NM-1:0] reqBySlave [NS];
  logic [NM-1:0] gntBySlave [NS];
  logic [2:0] slvIdx [NM];
  logic [NM-1:0] hit;
  logic wrStrobe;

  function automatic logic [31:0] beMerge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] be,
                                          input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return res & mask;
  endfunction : beMerge

  function automatic logic [4:0] splitBeats(input logic [2:0] split);
    case (split)
      bmx_pkg::SPLIT_SINGLE: return bmx_pkg::BEATS_1;
      bmx_pkg::SPLIT_BEAT4: return bmx_pkg::BEATS_4;
      bmx_pkg::SPLIT_BEAT8: return bmx_pkg::BEATS_8;
      bmx_pkg::SPLIT_BEAT16: return bmx_pkg::BEATS_16;
      default: return 5'h0;
    endcase
  endfunction : splitBeats

  // Priority field of master m within a slave's pair of priority words
  function automatic logic [1:0] priOf(input logic [31:0] priA,
                                       input logic [31:0] priB,
                                       input int m);
    if (m < 8)
      return priA[4*m +: 2];
    else
      return priB[4*(m-8) +: 2];
  endfunction : priOf

  // Returns {found, index}; ties in fixed mode go to the lowest index
  function automatic logic [MW:0] pickWinner(input logic [NM-1:0] reqs,
                                             input logic [MW-1:0] last,
                                             input logic fixedMode,
                                             input logic [31:0] priA,
                                             input logic [31:0] priB);
    logic found;
    logic [MW-1:0] win;
    logic [1:0] best;
    logic [1:0] cur;
    int idx;
    found = 1'b0;
    win = '0;
    best = 2'h0;
    cur = 2'h0;
    idx = 0;
    for (int k = 0; k < NM; k++)
    begin
      idx = fixedMode ? k : (int'(last) + 1 + k) % NM;
      cur = priOf(priA, priB, idx);
      if (reqs[idx] && (!found || (fixedMode && cur > best)))
      begin
        found = 1'b1;
        win = MW'(idx);
        best = cur;
      end
    end
    return {found, win};
  endfunction : pickWinner

  // Per-master decoders
  for (genvar m = 0; m < NM; m++)
  begin : gDecode
    // RULE16: private decoder per master
    assign slvIdx[m] = mAddr[m*32+28 +: 3];
    assign hit[m] = !mAddr[m*32+31] && CONN[m*NS + int'(slvIdx[m])];
    // RULE15: unmapped area errors
    assign mErr[m] = mReq[m] & ~hit[m];
  end

  always_comb
  begin
    for (int s = 0; s < NS; s++)
    begin
      for (int m = 0; m < NM; m++)
      begin
        reqBySlave[s][m] = mReq[m] & hit[m] & (int'(slvIdx[m]) == s);
      end
    end
  end

  always_comb
  begin
    mGnt = '0;
    for (int s = 0; s < NS; s++)
    begin
      mGnt = mGnt | gntBySlave[s];
    end
  end

  // RULE17: independent arbiter per slave
  for (genvar s = 0; s < NS; s++)
  begin : gArb
    logic [7:0] slotCntReg;
    logic [4:0] beatCntReg;
    logic [7:0] slotLimit;
    logic [1:0] parkType;
    logic [MW-1:0] fixedIdx;
    logic fixedMode;
    logic ownerReq;
    logic ownerIncr;
    logic beatDone;
    logic [4:0] pieceLen;
    logic breakPt;
    logic slotExp;
    logic locked;
    logic [MW:0] pick;
    logic newGrant;
    logic fixedBad;
    logic [1:0] parkEff;

    // RULE19: slave s uses register set s
    assign slotLimit = scfgReg[s][bmx_pkg::SLOT_LSB +: 8];
    assign parkType = scfgReg[s][bmx_pkg::PARK_LSB +: 2];
    assign fixedIdx = scfgReg[s][bmx_pkg::FIXED_LSB +: MW];
    assign fixedMode = scfgReg[s][bmx_pkg::ARBITRATION_POLICY_BIT];

    assign ownerReq = ownValidReg[s] & reqBySlave[s][ownerReg[s]];
    assign ownerIncr = mIncr[ownerReg[s]];
    assign beatDone = ownerReq & sReady[s];
    // RULE18: split setting of the owning master
    assign pieceLen = splitBeats(mcfgReg[ownerReg[s]][bmx_pkg::SPLIT_LSB +: 3]);
    // RULE1: no piece end when split is zero
    // RULE2: single-beat pieces
    // RULE3: four-beat pieces
    // RULE4: eight-beat pieces
    // RULE5: sixteen-beat pieces
    // Piece ends on the edge of its last beat, so no extra beat slips in
    assign breakPt = (pieceLen != 5'h0) && beatDone &&
                     (beatCntReg >= pieceLen - 5'h1);
    // RULE12: slot limit opens the burst
    assign slotExp = slotCntReg >= slotLimit;
    assign locked = ownerReq & ownerIncr & ~breakPt & ~slotExp;
    // RULE6: policy bit selects scheme
    // RULE14: higher field wins
    assign pick = pickWinner(reqBySlave[s], ownerReg[s], fixedMode,
                             priAReg[s], priBReg[s]);
    assign newGrant = pick[MW] & ~locked &
                      (~ownerReq | (pick[MW-1:0] != ownerReg[s]) |
                       breakPt | slotExp);

    // RULE8: unconnected parking master falls back to none
    assign fixedBad = (int'(fixedIdx) >= NM) ||
                      !CONN[int'(fixedIdx)*NS + s];
    // RULE7: parking index only in fixed parking
    assign parkEff = (parkType == bmx_pkg::PARK_FIXED && fixedBad) ?
                     bmx_pkg::PARK_NONE : parkType;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        ownerReg[s] <= '0;
        ownValidReg[s] <= 1'b0;
      end
      else if (newGrant)
      begin
        ownerReg[s] <= pick[MW-1:0];
        ownValidReg[s] <= 1'b1;
      end
      else if (!pick[MW])
      begin
        case (parkEff)
          // RULE9: idle slave disconnects
          bmx_pkg::PARK_NONE: ownValidReg[s] <= 1'b0;
          // RULE10: stays with last master
          bmx_pkg::PARK_LAST: ownValidReg[s] <= ownValidReg[s];
          // RULE11: parks on chosen master
          bmx_pkg::PARK_FIXED:
          begin
            ownerReg[s] <= fixedIdx;
            ownValidReg[s] <= 1'b1;
          end
          default: ownValidReg[s] <= 1'b0;
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        slotCntReg <= 8'h0;
        beatCntReg <= 5'h0;
      end
      // RULE21: restart count on grant
      else if (newGrant)
      begin
        slotCntReg <= 8'h0;
        beatCntReg <= 5'h0;
      end
      else
      begin
        if (ownerReq && slotCntReg != 8'hff)
          slotCntReg <= slotCntReg + 8'h1;
        if (beatDone && beatCntReg != 5'h1f)
          beatCntReg <= beatCntReg + 5'h1;
      end
    end

    assign sSel[s] = ownerReq;
    assign sMaster[s*MW +: MW] = ownerReg[s];
    always_comb
    begin
      gntBySlave[s] = '0;
      gntBySlave[s][ownerReg[s]] = beatDone;
    end
  end

  // Avalon-MM register slave
  // One wait cycle: read data registered, write lands on the final edge
  assign avsWaitrequest = (avsRead | avsWrite) &
                          (busStateReg != bmx_pkg::BUS_ACK);
  assign wrStrobe = avsWrite & (busStateReg == bmx_pkg::BUS_ACK);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busStateReg <= bmx_pkg::BUS_IDLE;
    else
    begin
      case (busStateReg)
        bmx_pkg::BUS_IDLE:
          if (avsRead || avsWrite)
            busStateReg <= bmx_pkg::BUS_ACK;
        bmx_pkg::BUS_ACK: busStateReg <= bmx_pkg::BUS_IDLE;
        default: busStateReg <= bmx_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      for (int m = 0; m < NM; m++)
        mcfgReg[m] <= bmx_pkg::MASTER_BURST_CONFIG_RESET;
    else if (wrStrobe)
      for (int m = 0; m < NM; m++)
        if (avsAddress[9:2] == 8'(int'(bmx_pkg::MASTER_BURST_CONFIG_BASE[9:2]) + m))
          mcfgReg[m] <= beMerge(mcfgReg[m], avsWriteData,
                                avsByteEnable, bmx_pkg::MASTER_BURST_CONFIG_MASK);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int s = 0; s < NS; s++)
      begin
        scfgReg[s] <= bmx_pkg::SLAVE_ARBITER_CONFIG_RESET;
        priAReg[s] <= bmx_pkg::PRI_RESET;
        priBReg[s] <= bmx_pkg::PRI_RESET;
      end
    end
    else if (wrStrobe)
    begin
      for (int s = 0; s < NS; s++)
      begin
        if (avsAddress[9:2] == 8'(int'(bmx_pkg::SLAVE_ARBITER_CONFIG_BASE[9:2]) + s))
          scfgReg[s] <= beMerge(scfgReg[s], avsWriteData,
                                avsByteEnable, bmx_pkg::SLAVE_ARBITER_CONFIG_MASK);
        if (avsAddress[9:2] == 8'(int'(bmx_pkg::PRI_BASE[9:2]) + 2*s))
          priAReg[s] <= beMerge(priAReg[s], avsWriteData,
                                avsByteEnable, bmx_pkg::PRI_MASK);
        if (avsAddress[9:2] == 8'(int'(bmx_pkg::PRI_BASE[9:2]) + 2*s + 1))
          priBReg[s] <= beMerge(priBReg[s], avsWriteData,
                                avsByteEnable, bmx_pkg::PRI_MASK);
      end
    end
  end

  // RULE20: side registers, stored only
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      for (int r = 0; r < bmx_pkg::SFR_COUNT; r++)
        sfrReg[r] <= bmx_pkg::SFR_RESET;
    else if (wrStrobe)
      for (int r = 0; r < bmx_pkg::SFR_COUNT; r++)
        if (avsAddress[9:2] == 8'(int'(bmx_pkg::SFR_BASE[9:2]) + r))
          sfrReg[r] <= beMerge(sfrReg[r], avsWriteData,
                               avsByteEnable, '1);
  end

  always_comb
  begin
    for (int r = 0; r < bmx_pkg::SFR_COUNT; r++)
      sfrOut[r*32 +: 32] = sfrReg[r];
  end

  // Unmapped and absent-index addresses read as zero, writes are dropped
  function automatic logic [31:0] readMux(input logic [7:0] w);
    logic [31:0] d;
    d = 32'h0;
    for (int m = 0; m < NM; m++)
      if (w == 8'(int'(bmx_pkg::MASTER_BURST_CONFIG_BASE[9:2]) + m))
        d = mcfgReg[m];
    for (int s = 0; s < NS; s++)
    begin
      if (w == 8'(int'(bmx_pkg::SLAVE_ARBITER_CONFIG_BASE[9:2]) + s))
        d = scfgReg[s];
      if (w == 8'(int'(bmx_pkg::PRI_BASE[9:2]) + 2*s))
        d = priAReg[s];
      if (w == 8'(int'(bmx_pkg::PRI_BASE[9:2]) + 2*s + 1))
        d = priBReg[s];
    end
    for (int r = 0; r < bmx_pkg::SFR_COUNT; r++)
      if (w == 8'(int'(bmx_pkg::SFR_BASE[9:2]) + r))
        d = sfrReg[r];
    if (w == bmx_pkg::OWNER_STAT_OFF[9:2])
      for (int s = 0; s < NS && s < 8; s++)
        d[4*s +: 4] = ownerReg[s];
    if (w == bmx_pkg::VALID_STAT_OFF[9:2])
      d[NS-1:0] = ownValidReg;
    return d;
  endfunction : readMux

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      avsReadData <= 32'h0;
    else if (avsRead && busStateReg == bmx_pkg::BUS_IDLE)
      avsReadData <= readMux(avsAddress[9:2]);
  end

endmodule : bmx_bus_switch_fabric

// *** design/bmx_pkg.sv ***
// Constants, field layout and enumerations of the bus switch fabric.
// Assumes a single system clock domain; shared by design and bench.
package bmx_pkg;

  localparam int NUM_MASTERS = 10;
  localparam int NUM_SLAVES = 8;
  localparam int MIDX_W = 4;
  localparam int SFR_COUNT = 16;

  // Byte offsets of the register groups
  localparam logic [9:0] MASTER_BURST_CONFIG_BASE = 10'h000;
  localparam logic [9:0] SLAVE_ARBITER_CONFIG_BASE = 10'h040;
  localparam logic [9:0] PRI_BASE = 10'h080;
  localparam logic [9:0] OWNER_STAT_OFF = 10'h100;
  localparam logic [9:0] VALID_STAT_OFF = 10'h104;
  localparam logic [9:0] SFR_BASE = 10'h110;

  // Field positions inside slave_arbiter_config; SPLIT_LSB is in the master burst config
  localparam int SLOT_LSB = 0;
  localparam int PARK_LSB = 16;
  localparam int FIXED_LSB = 18;
  localparam int ARBITRATION_POLICY_BIT = 24;
  localparam int SPLIT_LSB = 0;

  // Writable bits of each register kind; the rest read as zero
  localparam logic [31:0] MASTER_BURST_CONFIG_MASK = 32'h0000_0007;
  localparam logic [31:0] SLAVE_ARBITER_CONFIG_MASK = 32'h013f_00ff;
  localparam logic [31:0] PRI_MASK = 32'h3333_3333;

  // Values after reset
  localparam logic [31:0] MASTER_BURST_CONFIG_RESET = 32'h0000_0002;
  localparam logic [31:0] SLAVE_ARBITER_CONFIG_RESET = 32'h0000_0010;
  localparam logic [31:0] PRI_RESET = 32'h0000_0000;
  localparam logic [31:0] SFR_RESET = 32'h0000_0000;

  // Beats per piece of a split open-length burst
  localparam logic [4:0] BEATS_1 = 5'h1;
  localparam logic [4:0] BEATS_4 = 5'h4;
  localparam logic [4:0] BEATS_8 = 5'h8;
  localparam logic [4:0] BEATS_16 = 5'h10;

  typedef enum logic [2:0] {
    SPLIT_NONE = 3'b000,
    SPLIT_SINGLE = 3'b001,
    SPLIT_BEAT4 = 3'b010,
    SPLIT_BEAT8 = 3'b011,
    SPLIT_BEAT16 = 3'b100
  } bmx_split_t;

  typedef enum logic [1:0] {
    PARK_NONE = 2'b00,
    PARK_LAST = 2'b01,
    PARK_FIXED = 2'b10
  } bmx_park_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bmx_bus_state_t;

endpackage : bmx_pkg

// *** sim/bmx_bus_switch_fabric_assertions.sv ***
// Checker on the fabric's top-level ports.
// Assumes one clock domain and the hand-over timing of the fabric.
`timescale 1ns/1ps
module bmx_bsf_checker #(
  parameter int NM = 10,
  parameter int NS = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  input wire logic [NM*32-1:0] mAddr,
  input wire logic [NM-1:0] mReq,
  input wire logic [NM-1:0] mGnt,
  input wire logic [NM-1:0] mErr,
  input wire logic [NS-1:0] sSel,
  input wire logic [NS*bmx_pkg::MIDX_W-1:0] sMaster,
  input wire logic [NS-1:0] sReady
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence busAsk;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  sequence busAck;
    (avsRead || avsWrite) && !avsWaitrequest;
  endsequence
  ack_one_wait_a:
    assert property (busAsk |=> busAck)
    else $error("register access not answered after one wait");
  ack_after_ask_a:
    assert property (busAck |-> $past(avsWaitrequest))
    else $error("register access answered without a wait");
  gnt_count_a:
    assert property ($countones(mGnt) == $countones(sSel & sReady))
    else $error("grants differ from completed slave beats");
  for (genvar m = 0; m < NM; m++)
  begin : g_m
    err_on_hole_a:
      assert property (mReq[m] && mAddr[32*m+31] |-> mErr[m] && !mGnt[m])
      else $error("unmapped access not refused");
    err_needs_req_a:
      assert property (mErr[m] |-> mReq[m] && !mGnt[m])
      else $error("error without a request");
    gnt_needs_req_a:
      assert property (mGnt[m] |-> mReq[m] && !mErr[m])
      else $error("grant without a valid request");
  end
  for (genvar s = 0; s < NS; s++)
  begin : g_s
    sel_decode_a:
      assert property (sSel[s] |-> mReq[sMaster[4*s+:4]]
        && mAddr[32*sMaster[4*s+:4]+28+:4] == {1'b0, 3'(s)})
      else $error("slave selected by a request not decoded to it");
  end
endmodule : bmx_bsf_checker

bind bmx_bus_switch_fabric bmx_bsf_checker #(.NM(NM), .NS(NS)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
  .mAddr(mAddr), .mReq(mReq), .mGnt(mGnt), .mErr(mErr),
  .sSel(sSel), .sMaster(sMaster), .sReady(sReady)
);

// *** sim/bmx_slave_model.sv ***
// Behavioural slaves behind the fabric.
// Assumes sSel is a per-cycle level; waitCycles sets the beat delay.
`timescale 1ns/1ps
module bmx_slave_model #(
  parameter int NS = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [NS-1:0] sSel,
  input wire logic [1:0] waitCycles,
  output logic [NS-1:0] sReady
);
  for (genvar s = 0; s < NS; s++)
  begin : g_s
    logic [1:0] waitCount_reg;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        waitCount_reg <= 2'h0;
      else if (!sSel[s] || sReady[s])
        waitCount_reg <= 2'h0;
      else
        waitCount_reg <= waitCount_reg + 2'h1;
    end
    // Ready is never shown to an unselected slave port
    assign sReady[s] = sSel[s] && (waitCount_reg >= waitCycles);
  end
endmodule : bmx_slave_model

// *** sim/test_bus_matrix_arbiter.sv ***
// Self-checking bench: registers, decode, burst splits, arbitration
// and parking. Assumes the behavioural slave model on every slave.
`timescale 1ns/1ps
module test_bus_matrix_arbiter;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = '0;
  logic [3:0] avsByteEnable = 4'hf;
  logic [31:0] avsReadData;
  logic avsWaitrequest;
  logic [9:0] mReq = '0;
  logic [319:0] mAddr = '0;
  logic [9:0] mIncr = '0;
  logic [9:0] mGnt;
  logic [9:0] mErr;
  logic [7:0] sSel;
  logic [31:0] sMaster;
  logic [7:0] sReady;
  logic [511:0] sfrOut;
  logic [1:0] slow = 2'h0;
  logic [31:0] q;
  int n;
  int mismatches = 0;
  int checksDone = 0;
  int exps[5] = '{40, 1, 4, 8, 16};

  // Master 5 cannot reach slave 3
  bmx_bus_switch_fabric #(.CONN(~(80'h1 << 43))) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest), .mReq(mReq), .mAddr(mAddr),
    .mIncr(mIncr), .mGnt(mGnt), .mErr(mErr), .sSel(sSel),
    .sMaster(sMaster), .sReady(sReady), .sfrOut(sfrOut));
  bmx_slave_model slaves (.sys_clk(sys_clk), .rst_b(rst_b),
    .sSel(sSel), .waitCycles(slow), .sReady(sReady));

  initial
    forever #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic testDone;
    if (mismatches == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : testDone

  // Request held until the edge that sees waitrequest low; a hang is left
  // to the watchdog
  task automatic acc(input logic wr, input logic [9:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do
      @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : acc

  task automatic rdChk(input logic [9:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdChk

  task automatic drv(input int m, input logic [2:0] s, input logic inc,
    input logic on);
    mAddr[m*32+:32] <= {1'b0, s, 28'h0};
    mIncr[m] <= inc;
    mReq[m] <= on;
  endtask : drv

  task automatic beat(input int m, input logic [2:0] s, output int lat);
    @(posedge sys_clk);
    drv(m, s, 1'b0, 1'b1);
    lat = 0;
    do
    begin
      @(negedge sys_clk);
      lat++;
    end
    while (mGnt[m] !== 1'b1 && lat < 30);
    @(posedge sys_clk);
    mReq[m] <= 1'b0;
  endtask : beat

  task automatic regTest;
    logic [31:0] e;
    rdChk(10'h000, 32'h2);
    rdChk(10'h040, 32'h10);
    rdChk(10'h0bc, 32'h0);
    acc(1'b1, 10'h024, '1);
    rdChk(10'h024, 32'h7);
    acc(1'b1, 10'h028, '1);
    rdChk(10'h028, 32'h0);
    acc(1'b1, 10'h05c, '1);
    rdChk(10'h05c, 32'h013f00ff);
    acc(1'b1, 10'h060, '1);
    rdChk(10'h060, 32'h0);
    acc(1'b1, 10'h1fc, '1);
    rdChk(10'h1fc, 32'h0);
    for (int i = 0; i < 16; i++)
      acc(1'b1, bmx_pkg::SFR_BASE + 10'(4 * i), 32'hc0de0000 + i);
    avsByteEnable <= 4'h2;
    acc(1'b1, 10'h118, '1);
    avsByteEnable <= 4'hf;
    for (int i = 0; i < 16; i++)
    begin
      e = (i == 2) ? 32'hc0deff02 : 32'hc0de0000 + i;
      rdChk(bmx_pkg::SFR_BASE + 10'(4 * i), e);
      chk(sfrOut[i*32+:32], e);
    end
  endtask : regTest

  task automatic errTest;
    @(posedge sys_clk);
    mAddr[64+:32] <= 32'h8000_0000;
    mReq[2] <= 1'b1;
    drv(5, 3'h3, 1'b0, 1'b1);
    @(negedge sys_clk);
    chk({mErr[2], mGnt[2], sSel}, 10'h200);
    chk({mErr[5], mGnt[5]}, 2'h2);
    @(posedge sys_clk);
    mReq <= '0;
  endtask : errTest

  task automatic burstTest(input logic [2:0] code, input logic [7:0] slot,
    output int beats);
    int k;
    acc(1'b1, 10'h000, {29'h0, code});
    acc(1'b1, 10'h044, {24'h0, slot});
    beats = 0;
    k = 0;
    @(posedge sys_clk);
    drv(0, 3'h1, 1'b1, 1'b1);
    @(posedge sys_clk);
    drv(1, 3'h1, 1'b0, 1'b1);
    do
    begin
      @(negedge sys_clk);
      beats += int'(mGnt[0] === 1'b1);
      k++;
      if (k == 40)
      begin
        @(posedge sys_clk);
        mReq[0] <= 1'b0;
      end
    end
    while (mGnt[1] !== 1'b1 && k < 60);
    @(posedge sys_clk);
    mReq <= '0;
    mIncr <= '0;
  endtask : burstTest

  task automatic arbTest(input logic fixed, output int wins);
    int got;
    int k;
    acc(1'b1, 10'h048, {7'h0, fixed, 24'hff});
    wins = 0;
    got = 0;
    k = 0;
    @(posedge sys_clk);
    drv(3, 3'h2, 1'b0, 1'b1);
    drv(9, 3'h2, 1'b0, 1'b1);
    do
    begin
      @(negedge sys_clk);
      wins += int'(mGnt[9] === 1'b1);
      got += int'(mGnt != 10'h0);
      k++;
    end
    while (got < 4 && k < 40);
    @(posedge sys_clk);
    mReq <= '0;
  endtask : arbTest

  task automatic parkTest(input logic [1:0] t, input logic [3:0] f,
    input logic [4:0] expOwn, input int expLat);
    int lat;
    logic v;
    acc(1'b1, 10'h04c, {10'h0, f, t, 16'hff});
    beat(4, 3'h3, lat);
    acc(1'b0, bmx_pkg::VALID_STAT_OFF, 32'h0);
    v = q[3];
    acc(1'b0, bmx_pkg::OWNER_STAT_OFF, 32'h0);
    chk({v, v ? q[15:12] : 4'h0}, expOwn);
    beat(4, 3'h3, lat);
    chk(lat, expLat);
  endtask : parkTest

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    regTest();
    errTest();
    for (int i = 0; i < 5; i++)
    begin
      burstTest(3'(i), 8'hff, n);
      chk(n, exps[i]);
    end
    burstTest(3'h0, 8'h05, n);
    chk(n >= 5 && n <= 6, 1);
    burstTest(3'h0, 8'h05, n);
    chk(n >= 5 && n <= 6, 1);
    acc(1'b1, 10'h090, 32'h1000);
    acc(1'b1, 10'h094, 32'h20);
    arbTest(1'b0, n);
    chk(n, 2);
    slow <= 2'h2;
    arbTest(1'b1, n);
    chk(n, 4);
    slow <= 2'h0;
    parkTest(2'h0, 4'h6, 5'h00, 2);
    parkTest(2'h1, 4'h6, 5'h14, 1);
    parkTest(2'h2, 4'h6, 5'h16, 2);
    parkTest(2'h2, 4'h5, 5'h00, 2);
    testDone();
  end

  // Whole run needs under 500 cycles; allow 10000, twenty times that
  initial
  begin
    #1_000_000;
    mismatches++;
    testDone();
  end
endmodule : test_bus_matrix_arbiter
